// ### rtl/bcr_pkg.sv
// What this block does
// - Power-on reset restores all controls, some from OTP
// - Buck1 bit 7 steers scaling to pins
// - Span 00b: 500-1075 mV, 25 mV, 24 steps
// - Other spans: 12.5 mV steps, 32 steps
// - Slew step field bits 4-2, reset 000b
// - Slew field decodes to eight slew rates
// - Bit 1 forces PWM, clear gives automatic
// - Buck3 bits 7-5 read-write, reset 000b
// - Buck4 bit 0 picks slow or fast ramp
package bcr_pkg;

  // Register offsets
  localparam logic [7:0] BUCK1_CONTROL_OFS = 8'h00;
  localparam logic [7:0] BUCK2_CONTROL_OFS = 8'h01;
  localparam logic [7:0] BUCK3_CONTROL_OFS = 8'h02;
  localparam logic [7:0] BUCK4_CONTROL_OFS = 8'h03;
  localparam int         NUM_BUCKS         = 4;

  // Field positions
  localparam int PIN_SCALING_SELECT_BIT = 7;
  localparam int SPAN_MSB               = 6;
  localparam int SPAN_LSB               = 5;
  localparam int SLEW_MSB               = 4;
  localparam int SLEW_LSB               = 2;
  localparam int PWM_FORCE_BIT          = 1;
  localparam int RAMP_FAST_BIT          = 0;
  localparam int UPPER_MSB              = 7;
  localparam int UPPER_LSB              = 5;

  // Writable bit masks per register, reserved bits excluded
  localparam logic [7:0] WR_MASK [NUM_BUCKS] = '{8'hFE, 8'h1E, 8'hFE, 8'h1F};

  // Fixed reset values of non-OTP fields
  localparam logic [2:0] SLEW_RESET  = 3'h0;
  localparam logic [2:0] UPPER_RESET = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  // Slew rates in units of 0.01 mV/us, indexed by step code
  localparam logic [11:0] SLEW_RATE_TABLE [8] = '{12'hBB8, 12'h4E2, 12'h3AC, 12'h2EE,
                                                  12'h271, 12'h1D6, 12'h138, 12'h0FA};

  // Pin-path voltage tables in units of 0.1 mV
  localparam logic [1:0]  SPAN_WIDE       = 2'h0;
  localparam logic [13:0] SPAN_BASE [4]   = '{14'h1388, 14'h1B58, 14'h1770, 14'h1388};
  localparam logic [13:0] SPAN_TOP  [4]   = '{14'h2AF8, 14'h2AF8, 14'h2710, 14'h2328};
  localparam logic [8:0]  STEP_WIDE       = 9'h0FA;
  localparam logic [8:0]  STEP_FINE       = 9'h07D;
  localparam logic [4:0]  LAST_CODE_WIDE  = 5'h17;
  localparam logic [4:0]  LAST_CODE_FINE  = 5'h1F;

  // Start-up ramp timing
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int RAMP_SLOW_MIN_US   = 200;
  localparam int RAMP_FAST_MAX_US   = 60;
  localparam int RAMP_SLOW_CYCLES_D = (RAMP_SLOW_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAMP_FAST_CYCLES_D = (RAMP_FAST_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int RAMP_CNT_W         = 16;

  typedef enum logic [1:0] {RAMP_IDLE, RAMP_RUN, RAMP_DONE} bcr_ramp_e;

endpackage

// ### rtl/bcr_slew_decode.sv
`timescale 1ns/1ps
module bcr_slew_decode
  import bcr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [2:0]  slewStepCode,
  output logic      [11:0] slewRate
);

  logic [11:0] slewRate_r;
  logic [11:0] slewRate_nxt;

  // Table lookup of the output slew rate
  always_comb begin
    slewRate_nxt = SLEW_RATE_TABLE[slewStepCode];
  end

  // Register the decoded rate
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slewRate_r <= SLEW_RATE_TABLE[SLEW_RESET];
    end else begin
      slewRate_r <= slewRate_nxt;
    end
  end

  assign slewRate = slewRate_r;

  a_slew_fastest : assert property (@(posedge clk_sys) disable iff (reset)
    slewStepCode == 3'h0 |=> slewRate == 12'hBB8)
    else $error("Code zero does not give 30 mV/us");

  a_slew_slowest : assert property (@(posedge clk_sys) disable iff (reset)
    slewStepCode == 3'h7 |=> slewRate == 12'h0FA)
    else $error("Code seven does not give 2.5 mV/us");

endmodule

// ### rtl/bcr_buck_control_regs.sv
`timescale 1ns/1ps
module bcr_buck_control_regs
  import bcr_pkg::*;
#(
  parameter int RAMP_SLOW_CYCLES = RAMP_SLOW_CYCLES_D,
  parameter int RAMP_FAST_CYCLES = RAMP_FAST_CYCLES_D
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  output logic      [7:0]            regRdData,
  output logic                       regRdValid,
  input  wire logic                  otpPinScalingSelect,
  input  wire logic [1:0]            otpPinPathVoltageSpan,
  input  wire logic [NUM_BUCKS-1:0]  otpPwmForce,
  input  wire logic                  otpRampFast,
  input  wire logic                  buck1VoltageSelectPin,
  input  wire logic                  scalingPulsePin,
  input  wire logic                  scalingClockPin,
  input  wire logic [1:0]            buck1RegTableRange,
  input  wire logic [4:0]            pinPathCode,
  input  wire logic                  buck4StartReq,
  output logic                       pinScalingSelect,
  output logic                       scalingRegsIgnored,
  output logic [1:0]                 buck1TableRange,
  output logic                       buck1SelectGated,
  output logic                       scalingPulseGated,
  output logic                       scalingClockGated,
  output logic [13:0]                pinPathTarget,
  output logic [NUM_BUCKS-1:0][11:0] slewRate,
  output logic [NUM_BUCKS-1:0]       pwmForce,
  output logic [2:0]                 buck3UpperBits,
  output logic                       buck4RampFast,
  output logic                       buck4RampDone
);

  logic [7:0]            ctrl_r    [NUM_BUCKS];
  logic [7:0]            ctrl_nxt  [NUM_BUCKS];
  logic [7:0]            rdData_r;
  logic [7:0]            rdData_nxt;
  logic                  rdValid_r;
  logic                  addrHit;
  logic [1:0]            addrIdx;
  logic [5:0]            steer_r;
  logic [5:0]            steer_nxt;
  logic [13:0]           target_r;
  logic [13:0]           target_nxt;
  bcr_ramp_e             rampState_r;
  bcr_ramp_e             rampState_nxt;
  logic [RAMP_CNT_W-1:0] rampCnt_r;
  logic [RAMP_CNT_W-1:0] rampCnt_nxt;

  assign addrHit = regAddr < 8'(NUM_BUCKS);
  assign addrIdx = regAddr[1:0];

  // Register writes through the writable masks; reserved bits stay zero
  always_comb begin
    for (int i = 0; i < NUM_BUCKS; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      if (regWrEn && addrHit && addrIdx == 2'(i)) begin
        ctrl_nxt[i] = regWrData & WR_MASK[i];
      end
    end
  end

  // Power-on reset loads fixed and OTP values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r[0] <= {otpPinScalingSelect, otpPinPathVoltageSpan, SLEW_RESET, otpPwmForce[0], 1'b0};
      ctrl_r[1] <= {3'h0, SLEW_RESET, otpPwmForce[1], 1'b0};
      ctrl_r[2] <= {UPPER_RESET, SLEW_RESET, otpPwmForce[2], 1'b0};
      ctrl_r[3] <= {3'h0, SLEW_RESET, otpPwmForce[3], otpRampFast};
    end else begin
      for (int i = 0; i < NUM_BUCKS; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
    end
  end

  // Read path; unmapped offsets answer all ones
  always_comb begin
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      rdData_nxt = addrHit ? ctrl_r[addrIdx] : UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= rdData_nxt;
      rdValid_r <= regRdEn;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;

  // Scaling steering: pins path forces table range 00b and masks the select pin
  always_comb begin
    steer_nxt[0] = ctrl_r[0][PIN_SCALING_SELECT_BIT];
    steer_nxt[2:1] = steer_nxt[0] ? SPAN_WIDE : buck1RegTableRange;
    steer_nxt[3] = !steer_nxt[0] && buck1VoltageSelectPin;
    steer_nxt[4] = steer_nxt[0] && scalingPulsePin;
    steer_nxt[5] = steer_nxt[0] && scalingClockPin;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      steer_r <= 6'h00;
    end else begin
      steer_r <= steer_nxt;
    end
  end

  assign pinScalingSelect   = steer_r[0];
  assign scalingRegsIgnored = steer_r[0];
  assign buck1TableRange    = steer_r[2:1];
  assign buck1SelectGated   = steer_r[3];
  assign scalingPulseGated  = steer_r[4];
  assign scalingClockGated  = steer_r[5];

  // Pin-path code to target voltage, clamped at the span's last step
  always_comb begin
    logic [1:0]  span;
    logic [4:0]  lastCode;
    logic [4:0]  code;
    logic [8:0]  step;
    logic [13:0] sum;
    span     = ctrl_r[0][SPAN_MSB:SPAN_LSB];
    lastCode = (span == SPAN_WIDE) ? LAST_CODE_WIDE : LAST_CODE_FINE;
    step     = (span == SPAN_WIDE) ? STEP_WIDE : STEP_FINE;
    code     = (pinPathCode > lastCode) ? lastCode : pinPathCode;
    sum      = SPAN_BASE[span] + 14'(step * code);
    target_nxt = (sum > SPAN_TOP[span]) ? SPAN_TOP[span] : sum;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      target_r <= 14'h0000;
    end else begin
      target_r <= target_nxt;
    end
  end

  assign pinPathTarget = target_r;

  // Per-converter slew decode and mode outputs
  for (genvar g = 0; g < NUM_BUCKS; g++) begin : gen_buck
    bcr_slew_decode u_slew (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .slewStepCode (ctrl_r[g][SLEW_MSB:SLEW_LSB]),
      .slewRate     (slewRate[g])
    );
    assign pwmForce[g] = ctrl_r[g][PWM_FORCE_BIT];
  end

  assign buck3UpperBits = ctrl_r[2][UPPER_MSB:UPPER_LSB];
  assign buck4RampFast  = ctrl_r[3][RAMP_FAST_BIT];

  // Buck4 start-up ramp timer, length chosen by the ramp bit
  always_comb begin
    rampState_nxt = rampState_r;
    rampCnt_nxt   = rampCnt_r;
    unique case (rampState_r)
      RAMP_IDLE, RAMP_DONE: begin
        if (buck4StartReq) begin
          rampState_nxt = RAMP_RUN;
          rampCnt_nxt   = buck4RampFast ? RAMP_CNT_W'(RAMP_FAST_CYCLES - 1)
                                        : RAMP_CNT_W'(RAMP_SLOW_CYCLES - 1);
        end
      end
      RAMP_RUN: begin
        if (rampCnt_r == '0) begin
          rampState_nxt = RAMP_DONE;
        end else begin
          rampCnt_nxt = rampCnt_r - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rampState_r <= RAMP_IDLE;
      rampCnt_r   <= '0;
    end else begin
      rampState_r <= rampState_nxt;
      rampCnt_r   <= rampCnt_nxt;
    end
  end

  assign buck4RampDone = (rampState_r == RAMP_DONE);

  // Helper: cycles spent ramping and the ramp choice at start
  int   rampLen;
  logic rampFastAtStart;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rampLen         <= 0;
      rampFastAtStart <= 1'b0;
    end else if (rampState_r != RAMP_RUN && buck4StartReq) begin
      rampLen         <= 0;
      rampFastAtStart <= buck4RampFast;
    end else if (rampState_r == RAMP_RUN) begin
      rampLen <= rampLen + 1;
    end
  end

  sequence s_write_buck (int idx);
    regWrEn && addrHit && addrIdx == 2'(idx);
  endsequence

  sequence s_read_buck;
    regRdEn && addrHit;
  endsequence

  a_reserved_read_zero : assert property (@(posedge clk_sys) disable iff (reset)
    s_read_buck |=> (regRdData & ~WR_MASK[$past(addrIdx)]) == 8'h00)
    else $error("Reserved bits read back nonzero");

  a_unmapped_read_ones : assert property (@(posedge clk_sys) disable iff (reset)
    regRdEn && !addrHit |=> regRdValid && regRdData == 8'hFF)
    else $error("Unmapped read did not return all ones");

  a_buck3_upper_store : assert property (@(posedge clk_sys) disable iff (reset)
    s_write_buck(2) |=> buck3UpperBits == $past(regWrData[7:5]))
    else $error("Buck3 upper bits not stored");

  a_buck2_upper_zero : assert property (@(posedge clk_sys) disable iff (reset)
    s_write_buck(1) |=> ctrl_r[1][7:5] == 3'h0)
    else $error("Buck2 upper bits not read-only");

  a_pwm_force_write : assert property (@(posedge clk_sys) disable iff (reset)
    s_write_buck(3) |=> pwmForce[3] == $past(regWrData[1]))
    else $error("Mode bit not applied to buck4");

  a_pin_force_range : assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_r[0][7] |=> buck1TableRange == 2'h0 && !buck1SelectGated)
    else $error("Pin scaling did not force range 00b");

  a_wide_span_target : assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_r[0][6:5] == 2'h0 && pinPathCode == 5'h00 |=> pinPathTarget == 14'h1388)
    else $error("Span 00b first step is not 500 mV");

  a_fine_span_step : assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_r[0][6:5] == 2'h1 && pinPathCode == 5'h02 |=> pinPathTarget == 14'h1C52)
    else $error("Span 01b third step is not 725 mV");

  a_reset_slew_zero : assert property (@(posedge clk_sys)
    reset |=> ctrl_r[0][4:2] == 3'h0 && ctrl_r[3][4:2] == 3'h0)
    else $error("Slew field not cleared by reset");

  a_ramp_length : assert property (@(posedge clk_sys) disable iff (reset)
    rampState_r == RAMP_RUN && rampState_nxt == RAMP_DONE |->
      rampLen + 1 == (rampFastAtStart ? RAMP_FAST_CYCLES : RAMP_SLOW_CYCLES))
    else $error("Start-up ramp length wrong");

endmodule

// ### verification/bcr_testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int SLOW_N = 20;
  localparam int FAST_N = 6;
  logic             clk_sys;
  logic             reset;
  logic             regWrEn;
  logic             regRdEn;
  logic [7:0]       regAddr;
  logic [7:0]       regWrData;
  logic [7:0]       regRdData;
  logic             regRdValid;
  logic             otpPinScalingSelect;
  logic [1:0]       otpPinPathVoltageSpan;
  logic [3:0]       otpPwmForce;
  logic             otpRampFast;
  logic             buck1VoltageSelectPin;
  logic             scalingPulsePin;
  logic             scalingClockPin;
  logic [1:0]       buck1RegTableRange;
  logic [4:0]       pinPathCode;
  logic             buck4StartReq;
  logic             pinScalingSelect;
  logic             scalingRegsIgnored;
  logic [1:0]       buck1TableRange;
  logic             buck1SelectGated;
  logic             scalingPulseGated;
  logic             scalingClockGated;
  logic [13:0]      pinPathTarget;
  logic [3:0][11:0] slewRate;
  logic [3:0]       pwmForce;
  logic [2:0]       buck3UpperBits;
  logic             buck4RampFast;
  logic             buck4RampDone;
  int               n_fail;
  int               compares;

  bcr_buck_control_regs #(.RAMP_SLOW_CYCLES(SLOW_N), .RAMP_FAST_CYCLES(FAST_N)) bcr_buck_control_regs_inst (
    .clk_sys(clk_sys), .reset(reset), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .otpPinScalingSelect(otpPinScalingSelect), .otpPinPathVoltageSpan(otpPinPathVoltageSpan),
    .otpPwmForce(otpPwmForce), .otpRampFast(otpRampFast), .buck1VoltageSelectPin(buck1VoltageSelectPin),
    .scalingPulsePin(scalingPulsePin), .scalingClockPin(scalingClockPin),
    .buck1RegTableRange(buck1RegTableRange), .pinPathCode(pinPathCode), .buck4StartReq(buck4StartReq),
    .pinScalingSelect(pinScalingSelect), .scalingRegsIgnored(scalingRegsIgnored),
    .buck1TableRange(buck1TableRange), .buck1SelectGated(buck1SelectGated),
    .scalingPulseGated(scalingPulseGated), .scalingClockGated(scalingClockGated),
    .pinPathTarget(pinPathTarget), .slewRate(slewRate), .pwmForce(pwmForce),
    .buck3UpperBits(buck3UpperBits), .buck4RampFast(buck4RampFast), .buck4RampDone(buck4RampDone));

  // Clock generation at 250 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask

  // Read answers on the taking edge itself, checked 1 ns later
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    check("regRdValid", 16'h1, {15'h0, regRdValid});
    check("regRdData", {8'h0, exp}, {8'h0, regRdData});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Two resets with different OTP patterns, then every register read
  task automatic test_reset(input logic sel, input logic [1:0] span, input logic [3:0] pwm, input logic ramp);
    @(posedge clk_sys);
    otpPinScalingSelect   <= sel;
    otpPinPathVoltageSpan <= span;
    otpPwmForce           <= pwm;
    otpRampFast           <= ramp;
    reset                 <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd_check(8'h00, {sel, span, 3'h0, pwm[0], 1'b0});
    rd_check(8'h01, {6'h00, pwm[1], 1'b0});
    rd_check(8'h02, {6'h00, pwm[2], 1'b0});
    rd_check(8'h03, {6'h00, pwm[3], ramp});
    check("slewRate0", 16'h0BB8, {4'h0, slewRate[0]});
  endtask

  // All-ones writes land only in writable bits; unmapped offset reads FFh
  task automatic test_access();
    for (int i = 0; i < 4; i++) wr(i[7:0], 8'hFF);
    settle(1);
    check("pwmForce", 16'hF, {12'h0, pwmForce});
    check("buck3UpperBits", 16'h7, {13'h0, buck3UpperBits});
    check("buck4RampFast", 16'h1, {15'h0, buck4RampFast});
    rd_check(8'h00, 8'hFE);
    rd_check(8'h01, 8'h1E);
    rd_check(8'h02, 8'hFE);
    rd_check(8'h03, 8'h1F);
    wr(8'h04, 8'h00);
    rd_check(8'h04, 8'hFF);
    rd_check(8'h00, 8'hFE);
    for (int i = 0; i < 4; i++) wr(i[7:0], 8'h00);
    settle(1);
    check("pwmForce", 16'h0, {12'h0, pwmForce});
    check("buck3UpperBits", 16'h0, {13'h0, buck3UpperBits});
  endtask

  // Every slew code on every converter, each with a different code
  task automatic test_slew();
    int rates [8];
    int code;
    rates = '{3000, 1250, 940, 750, 625, 470, 312, 250};
    for (int c = 0; c < 8; c++) begin
      for (int b = 0; b < 4; b++) wr(b[7:0], 8'(((c + b) % 8) << 2));
      settle(2);
      for (int b = 0; b < 4; b++) begin
        code = (c + b) % 8;
        check("slewRate", 16'(rates[code]), {4'h0, slewRate[b]});
      end
    end
  endtask

  // Pin steering on and off with all pins held high
  task automatic test_steer();
    @(posedge clk_sys);
    buck1RegTableRange    <= 2'h3;
    buck1VoltageSelectPin <= 1'b1;
    scalingPulsePin       <= 1'b1;
    scalingClockPin       <= 1'b1;
    for (int on = 1; on >= 0; on--) begin
      wr(8'h00, on[0] ? 8'h80 : 8'h00);
      settle(3);
      check("pinScalingSelect", 16'(on), {15'h0, pinScalingSelect});
      check("scalingRegsIgnored", 16'(on), {15'h0, scalingRegsIgnored});
      check("buck1TableRange", on[0] ? 16'h0 : 16'h3, {14'h0, buck1TableRange});
      check("buck1SelectGated", 16'(1 - on), {15'h0, buck1SelectGated});
      check("scalingPulseGated", 16'(on), {15'h0, scalingPulseGated});
      check("scalingClockGated", 16'(on), {15'h0, scalingClockGated});
    end
  endtask

  // First and last code of each span; code 31 on the wide span clamps
  task automatic test_target();
    int base [4];
    int step;
    int last;
    base = '{5000, 7000, 6000, 5000};
    for (int s = 0; s < 4; s++) begin
      step = (s == 0) ? 250 : 125;
      last = (s == 0) ? 23 : 31;
      wr(8'h00, {1'b1, s[1:0], 5'h00});
      pinPathCode <= 5'h00;
      settle(3);
      check("pinPathTarget", 16'(base[s]), {2'h0, pinPathTarget});
      @(posedge clk_sys);
      pinPathCode <= 5'h02;
      settle(3);
      check("pinPathTarget", 16'(base[s] + step * 2), {2'h0, pinPathTarget});
      @(posedge clk_sys);
      pinPathCode <= 5'h1F;
      settle(3);
      check("pinPathTarget", 16'(base[s] + step * last), {2'h0, pinPathTarget});
    end
  endtask

  // Slow then fast start-up ramp, done edge counted from the taking edge
  task automatic test_ramp();
    int n;
    for (int f = 0; f < 2; f++) begin
      wr(8'h03, {7'h0, f[0]});
      settle(1);
      check("buck4RampFast", 16'(f), {15'h0, buck4RampFast});
      @(posedge clk_sys);
      buck4StartReq <= 1'b1;
      @(posedge clk_sys);
      buck4StartReq <= 1'b0;
      #1;
      check("buck4RampDone", 16'h0, {15'h0, buck4RampDone});
      n = 0;
      while (n < 100 && buck4RampDone !== 1'b1) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check("rampEdges", 16'(f ? FAST_N : SLOW_N), 16'(n));
    end
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    n_fail                = 0;
    compares              = 0;
    reset                 = 1'b1;
    regWrEn               = 1'b0;
    regRdEn               = 1'b0;
    regAddr               = 8'h00;
    regWrData             = 8'h00;
    otpPinScalingSelect   = 1'b0;
    otpPinPathVoltageSpan = 2'h0;
    otpPwmForce           = 4'h0;
    otpRampFast           = 1'b0;
    buck1VoltageSelectPin = 1'b0;
    scalingPulsePin       = 1'b0;
    scalingClockPin       = 1'b0;
    buck1RegTableRange    = 2'h0;
    pinPathCode           = 5'h00;
    buck4StartReq         = 1'b0;
    test_reset(1'b1, 2'h2, 4'hA, 1'b1);
    test_reset(1'b0, 2'h1, 4'h5, 1'b0);
    test_access();
    test_slew();
    test_steer();
    test_target();
    test_ramp();
    final_report();
  end
endmodule
